// ==== shared/ordbd_pkg.sv ====
// Constants and carrier types for the on-chip RAM bank decoder
package ordbd_pkg;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 32;
  localparam int WORD_W = 16;
  localparam int BANK_W = 6;
  localparam int WORD_IDX_W = 12;
  localparam int BLOCK_SHIFT = 13;
  localparam int DUAL_BLOCKS = 8;
  localparam int SINGLE_BLOCKS = 32;
  localparam int BLOCK_WORDS = 4096;
  localparam int NUM_BLOCKS = DUAL_BLOCKS + SINGLE_BLOCKS;
  localparam int DUAL_PORTS = 2;
  localparam int SINGLE_PORTS = 1;
  localparam int IO_SPACE_WORDS = 65536;
  localparam logic [ADDR_W-1:0] DUAL_LO = 24'h000000;
  localparam logic [ADDR_W-1:0] DUAL_HI = 24'h00FFFF;
  localparam logic [ADDR_W-1:0] SINGLE_LO = 24'h010000;
  localparam logic [ADDR_W-1:0] SINGLE_HI = 24'h04FFFF;
  localparam logic [ADDR_W-1:0] DMA_DUAL_LO = 24'h010000;
  localparam logic [ADDR_W-1:0] DMA_DUAL_HI = 24'h01FFFF;
  localparam logic [ADDR_W-1:0] DMA_DUAL_OFS = 24'h010000;
  localparam logic [ADDR_W-1:0] DMA_SINGLE_LO = 24'h090000;
  localparam logic [ADDR_W-1:0] DMA_SINGLE_HI = 24'h0CFFFF;
  localparam logic [ADDR_W-1:0] DMA_SINGLE_OFS = 24'h080000;
  localparam logic [ADDR_W-1:0] LOW_WINDOW_BYTES = 24'h0000C0;
  localparam int REQ_PROG = 0;
  localparam int REQ_RD32 = 1;
  localparam int REQ_RD16A = 2;
  localparam int REQ_RD16B = 3;
  localparam int REQ_WR16A = 4;
  localparam int REQ_WR16B = 5;
  localparam int REQ_DMA0 = 6;
  localparam int NUM_DMA = 4;
  localparam int REQ_USB = REQ_DMA0 + NUM_DMA;
  localparam int NUM_REQ = REQ_USB + 1;

  typedef enum logic [1:0] {
    ORDBD_VIEW_CPU = 2'b00,
    ORDBD_VIEW_DMA = 2'b01,
    ORDBD_VIEW_USB = 2'b10
  } ordbd_view_t;

  typedef struct packed {
    logic valid;
    logic we;
    logic wide;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } ordbd_req_t;

  typedef struct packed {
    logic ready;
    logic to_ram;
    logic to_low_window;
    logic to_other;
  } ordbd_route_t;

  typedef struct packed {
    logic in_ram;
    logic [ADDR_W-1:0] addr;
  } ordbd_xlate_t;
endpackage

// ==== verilog/ordbd_decoder.sv ====
// On-chip RAM bank decoder, arbiter and storage for dual- and single-access blocks
// Operation
// R1: CPU bytes 000000h-00FFFFh decode to the dual-access RAM region.
// R2: Dual region is eight 4K-word blocks, one per 8K-byte slice.
// R3: Each dual-access block serves two accesses per cycle, any read/write mix.
// R4: Dual blocks reachable from program, data and DMA buses.
// R5: DMA bytes 10000h-1FFFFh reach dual blocks at CPU address minus 10000h.
// R6: Lowest 192 bytes of dual block 0 steer to the register window.
// R7: CPU bytes 010000h-04FFFFh decode to the single-access RAM region.
// R8: Single region is 32 blocks of 4K words, one per 8K-byte slice.
// R9: Each single-access block serves one read or one write per cycle.
// R10: Single blocks reachable from program, data, DMA and USB DMA buses.
// R11: DMA/USB bytes 90000h-CFFFFh reach single blocks in CPU block order.
// R12: CPU side has program bus, 32-bit read, two 16-bit reads, two writes.
// R13: Up to four data reads and two data writes served per cycle.
// R14: Each DMA controller issues at most one 32-bit transfer per cycle.
// R15: Fetch unit reads 32-bit program words into its own 128-byte queue.
// R16: Address space is 16M bytes unified; I/O space is separate, 64K words.
// R17: Oversubscribed blocks grant by fixed priority; losers stall for later.
// R18: Addresses outside both RAM regions pass on unchanged to other decoders.
`timescale 1ns/1ps
module ordbd_decoder (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire ordbd_pkg::ordbd_req_t req_i [ordbd_pkg::NUM_REQ],
  output ordbd_pkg::ordbd_route_t route_o [ordbd_pkg::NUM_REQ],
  output logic [ordbd_pkg::DATA_W-1:0] rdata_o [ordbd_pkg::NUM_REQ],
  output logic [ordbd_pkg::NUM_REQ-1:0] rvalid_o
);
  import ordbd_pkg::*;

  // Which address view a requester uses
  function automatic ordbd_view_t view_of(input int idx);
    if (idx == REQ_USB) begin
      return ORDBD_VIEW_USB;
    end else if (idx >= REQ_DMA0) begin
      return ORDBD_VIEW_DMA;
    end else begin
      return ORDBD_VIEW_CPU;
    end
  endfunction

  // Fix the bus shape each processor port is able to present
  function automatic ordbd_req_t shape(input int idx, input ordbd_req_t r);
    ordbd_req_t s;
    s = r;
    if (idx == REQ_PROG || idx == REQ_RD32) begin // [R12] [R15]
      s.we = 1'b0;
      s.wide = 1'b1;
    end else if (idx == REQ_RD16A || idx == REQ_RD16B) begin // [R12]
      s.we = 1'b0;
      s.wide = 1'b0;
    end else if (idx == REQ_WR16A || idx == REQ_WR16B) begin // [R12]
      s.we = 1'b1;
      s.wide = 1'b0;
    end
    return s;
  endfunction

  // Translate a requester address into the processor byte view
  function automatic ordbd_xlate_t xlate(input ordbd_view_t v, input logic [ADDR_W-1:0] a);
    ordbd_xlate_t x;
    x.in_ram = 1'b0;
    x.addr = a;
    case (v)
      ORDBD_VIEW_CPU: begin
        x.in_ram = (a >= DUAL_LO && a <= DUAL_HI) || (a >= SINGLE_LO && a <= SINGLE_HI); // [R1] [R7] [R16]
      end
      ORDBD_VIEW_DMA: begin
        if (a >= DMA_DUAL_LO && a <= DMA_DUAL_HI) begin // [R5] [R4]
          x.in_ram = 1'b1;
          x.addr = a - DMA_DUAL_OFS;
        end else if (a >= DMA_SINGLE_LO && a <= DMA_SINGLE_HI) begin // [R11]
          x.in_ram = 1'b1;
          x.addr = a - DMA_SINGLE_OFS;
        end
      end
      ORDBD_VIEW_USB: begin
        if (a >= DMA_SINGLE_LO && a <= DMA_SINGLE_HI) begin // [R10] [R11]
          x.in_ram = 1'b1;
          x.addr = a - DMA_SINGLE_OFS;
        end
      end
      default: begin
        x.in_ram = 1'b0;
      end
    endcase
    return x;
  endfunction

  ordbd_req_t req_s [NUM_REQ];
  ordbd_xlate_t xl [NUM_REQ];
  logic [BANK_W-1:0] bank [NUM_REQ];
  logic [WORD_IDX_W-1:0] word_lo [NUM_REQ];
  logic [WORD_IDX_W-1:0] word_hi [NUM_REQ];
  logic [NUM_REQ-1:0] low_hit;
  logic [NUM_REQ-1:0] ram_hit;
  logic [NUM_REQ-1:0] other_hit;
  logic [NUM_REQ-1:0] grant;
  logic [WORD_W-1:0] mem [NUM_BLOCKS*BLOCK_WORDS];
  logic [DATA_W-1:0] rdata_reg [NUM_REQ];
  logic [NUM_REQ-1:0] rvalid_reg;

  genvar g;
  generate
    for (g = 0; g < NUM_REQ; g++) begin : g_dec
      assign req_s[g] = shape(g, req_i[g]);
      assign xl[g] = xlate(view_of(g), req_s[g].addr);
      // Block index: 0..7 dual, 8..39 single, one per 8K-byte slice
      assign bank[g] = xl[g].addr[BLOCK_SHIFT+BANK_W-1:BLOCK_SHIFT]; // [R2] [R8]
      // Wide accesses use the aligned word pair inside one block
      assign word_lo[g] = req_s[g].wide ? {xl[g].addr[BLOCK_SHIFT-1:2], 1'b0} : xl[g].addr[BLOCK_SHIFT-1:1];
      assign word_hi[g] = {xl[g].addr[BLOCK_SHIFT-1:2], 1'b1};
      assign low_hit[g] = req_s[g].valid && xl[g].in_ram && (xl[g].addr < LOW_WINDOW_BYTES); // [R6]
      assign ram_hit[g] = req_s[g].valid && xl[g].in_ram && !low_hit[g];
      assign other_hit[g] = req_s[g].valid && !xl[g].in_ram; // [R18]
      assign route_o[g].to_ram = ram_hit[g];
      assign route_o[g].to_low_window = low_hit[g]; // [R6]
      assign route_o[g].to_other = other_hit[g]; // [R18]
      // Forwarded traffic is never held here; only RAM losers stall
      assign route_o[g].ready = !ram_hit[g] || grant[g]; // [R17]
    end
  endgenerate

  // Per-block grants: lower index wins; dual blocks take two, single one
  always_comb begin
    int used;
    int cap;
    used = 0;
    cap = 0;
    for (int i = 0; i < NUM_REQ; i++) begin
      used = 0;
      for (int j = 0; j < i; j++) begin
        if (ram_hit[j] && bank[j] == bank[i]) begin
          used = used + 1;
        end
      end
      cap = (int'(bank[i]) < DUAL_BLOCKS) ? DUAL_PORTS : SINGLE_PORTS; // [R3] [R9]
      grant[i] = ram_hit[i] && (used < cap); // [R17] [R13] [R14]
    end
  end

  // Storage writes; two granted writes to one dual block land together
  always_ff @(posedge sys_clk_i) begin
    for (int i = 0; i < NUM_REQ; i++) begin
      if (grant[i] && req_s[i].we) begin // [R3] [R9]
        if (req_s[i].wide) begin
          mem[{bank[i], word_lo[i]}] <= req_s[i].wdata[DATA_W-1:WORD_W];
          mem[{bank[i], word_hi[i]}] <= req_s[i].wdata[WORD_W-1:0];
        end else begin
          mem[{bank[i], word_lo[i]}] <= req_s[i].wdata[WORD_W-1:0];
        end
      end
    end
  end

  // Read data returns one cycle after the grant; reads see the old contents
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rvalid_reg <= '0;
      for (int i = 0; i < NUM_REQ; i++) begin
        rdata_reg[i] <= 32'h00000000;
      end
    end else begin
      for (int i = 0; i < NUM_REQ; i++) begin
        rvalid_reg[i] <= grant[i] && !req_s[i].we;
        if (grant[i] && !req_s[i].we) begin // [R13]
          rdata_reg[i] <= req_s[i].wide ? {mem[{bank[i], word_lo[i]}], mem[{bank[i], word_hi[i]}]}
                                         : {16'h0000, mem[{bank[i], word_lo[i]}]};
        end
      end
    end
  end

  assign rdata_o = rdata_reg;
  assign rvalid_o = rvalid_reg;
endmodule

// ==== verification/ordbd_decoder_monitor.sv ====
// Assertion checker for the RAM bank decoder
`timescale 1ns/1ps
module ordbd_decoder_monitor (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire ordbd_pkg::ordbd_req_t req_i [ordbd_pkg::NUM_REQ],
  input wire ordbd_pkg::ordbd_route_t route_o [ordbd_pkg::NUM_REQ],
  input wire logic [ordbd_pkg::DATA_W-1:0] rdata_o [ordbd_pkg::NUM_REQ],
  input wire logic [ordbd_pkg::NUM_REQ-1:0] rvalid_o
);
  import ordbd_pkg::*;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  wire v2 = req_i[2].valid;
  wire [23:0] a2 = req_i[2].addr;
  wire take2 = v2 && route_o[2].ready && route_o[2].to_ram;
  wire both = v2 && req_i[3].valid && !req_i[0].valid && !req_i[1].valid && a2[18:13] == req_i[3].addr[18:13]
    && route_o[2].to_ram && route_o[3].to_ram;
  rd_answer_a: assert property (take2 |=> rvalid_o[2]) else $error("read not answered");
  dual_map_a: assert property (v2 && a2 >= 24'hC0 && a2 <= 24'hFFFF |-> route_o[2].to_ram) else $error("dual");
  low_win_a: assert property (v2 && a2 < 24'hC0 |-> route_o[2].to_low_window && !route_o[2].to_ram)
    else $error("low window");
  single_map_a: assert property (v2 && a2 inside {[24'h10000:24'h4FFFF]} |-> route_o[2].to_ram) else $error("single");
  pass_on_a: assert property (v2 && a2 > 24'h4FFFF |-> route_o[2].to_other && route_o[2].ready)
    else $error("pass on");
  dma_dual_a: assert property (req_i[6].valid && req_i[6].addr inside {[24'h100C0:24'h1FFFF]} |-> route_o[6].to_ram)
    else $error("dma dual");
  single_prio_a: assert property (both && a2[18:13] >= 8 |-> route_o[2].ready && !route_o[3].ready)
    else $error("priority");
  dual_pair_a: assert property (both && a2[18:13] < 8 |-> route_o[2].ready && route_o[3].ready)
    else $error("dual pair");
  cover property (take2);
  cover property (both && !route_o[3].ready);
  cover property (req_i[6].valid && route_o[6].to_ram);
endmodule
bind ordbd_decoder ordbd_decoder_monitor ordbd_decoder_monitor_i (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
  .req_i(req_i), .route_o(route_o), .rdata_o(rdata_o), .rvalid_o(rvalid_o));

// ==== verification/ordbd_requester_model.sv ====
// DMA-side requester that holds one transfer until it is taken
`timescale 1ns/1ps
module ordbd_requester_model (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire ordbd_pkg::ordbd_req_t cmd_i,
  input wire logic ready_i,
  output ordbd_pkg::ordbd_req_t req_o
);
  import ordbd_pkg::*;
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      req_o <= '0;
    end else if (req_o.valid && ready_i) begin
      req_o <= {1'b0, ~req_o[$bits(ordbd_req_t)-2:0]};
    end else if (cmd_i.valid && !req_o.valid) begin
      req_o <= cmd_i;
    end
  end
endmodule

// ==== verification/ordbd_decoder_tb.sv ====
// Self-checking bench for the RAM bank decoder
`timescale 1ns/1ps
module ordbd_decoder_tb;
  import ordbd_pkg::*;
  logic sys_clk_i = 0;
  logic resetn_i = 0;
  ordbd_req_t drv [NUM_REQ];
  ordbd_req_t req [NUM_REQ];
  ordbd_req_t dma_q, usb_q;
  ordbd_route_t route [NUM_REQ];
  logic [31:0] rdata [NUM_REQ];
  logic [NUM_REQ-1:0] rvalid;
  logic [31:0] exp_q [NUM_REQ][$];
  int errors = 0;
  int total_checks = 0;
  int seed = 32'h3353CE6A;
  logic [23:0] a;
  logic [31:0] d;
  initial forever #50 sys_clk_i = ~sys_clk_i;
  always_comb begin
    req = drv;
    req[6] = dma_q;
    req[10] = usb_q;
  end
  ordbd_decoder ordbd_decoder_i (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .req_i(req), .route_o(route),
    .rdata_o(rdata), .rvalid_o(rvalid));
  ordbd_requester_model ordbd_requester_model_dma_i (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .cmd_i(drv[6]),
    .ready_i(route[6].ready), .req_o(dma_q));
  ordbd_requester_model ordbd_requester_model_usb_i (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .cmd_i(drv[10]),
    .ready_i(route[10].ready), .req_o(usb_q));
  task automatic chk(logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic acc(int p, logic w, logic wd, logic [23:0] ad, logic [31:0] dd);
    int n = 0;
    drv[p] <= '{1'b1, w, wd, ad, dd};
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (!(req[p].valid === 1'b1 && route[p].ready === 1'b1) && n < 20);
    if (n == 20) chk(0, 1);
    drv[p].valid <= 1'b0;
    // Let the release settle before the same port is driven again
    @(posedge sys_clk_i);
  endtask
  // Forwarded request: compare {ready,to_ram,to_low_window,to_other} once it is presented
  task automatic route_chk(int p, logic [23:0] ad, logic [3:0] e);
    int n = 0;
    drv[p] <= '{1'b1, 1'b0, 1'b0, ad, 32'h00000000};
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (req[p].valid !== 1'b1 && n < 20);
    chk(32'(e), 32'(route[p]));
    drv[p].valid <= 1'b0;
    @(posedge sys_clk_i);
  endtask
  task automatic rd(int p, logic wd, logic [23:0] ad, logic [31:0] e);
    exp_q[p].push_back(e);
    acc(p, 0, wd, ad, 0);
  endtask
  task automatic results;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge sys_clk_i) begin
    for (int p = 0; p < NUM_REQ; p++) begin
      if (rvalid[p] === 1'b1) chk(exp_q[p].size() ? exp_q[p].pop_front() : 32'hX, rdata[p]);
    end
  end
  initial begin
    #2000000;
    chk(0, 1);
    results();
  end
  initial begin
    foreach (drv[p]) drv[p] = '0;
    repeat (10) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    for (int b = 0; b < NUM_BLOCKS; b++) begin
      a = (24'(b) << 13) | 24'h100 | (24'($random(seed)) & 24'h0EFE);
      d = $random(seed);
      acc(4, 1, 0, a, d);
      rd(2, 0, a, {16'h0, d[15:0]});
    end
    a = 24'h6100 | (24'($random(seed)) & 24'h0EFC);
    d = $random(seed);
    acc(6, 1, 1, a + DMA_DUAL_OFS, d);
    rd(1, 1, a, d);
    fork
      rd(2, 0, a, {16'h0, d[31:16]});
      rd(3, 0, a | 24'h2, {16'h0, d[15:0]});
    join
    acc(10, 1, 1, 24'h0CE200, d);
    rd(0, 1, 24'h04E200, d);
    rd(7, 1, 24'h0CE200, d);
    fork
      rd(2, 0, 24'h04E200, {16'h0, d[31:16]});
      rd(3, 0, 24'h04E202, {16'h0, d[15:0]});
    join
    route_chk(2, 24'h000040, 4'b1010);
    route_chk(7, 24'h010040, 4'b1010);
    route_chk(2, 24'h600000, 4'b1001);
    route_chk(10, 24'h012000, 4'b1001);
    repeat (3) @(posedge sys_clk_i);
    for (int p = 0; p < NUM_REQ; p++) chk(exp_q[p].size(), 0);
    results();
  end
endmodule
